// ---- src/bdm_addr_gen.sv ----
// Data address former: banked, access-bank and full-address forms.
// Assumes operand fields stay stable for the whole instruction cycle.
`timescale 1ns/100ps
module bdm_addr_gen (
	// Operation fields
	input wire bdm_pkg::bdm_op_t op_kind,
	input wire logic op_access,
	input wire logic [7:0] op_offset,
	input wire logic [11:0] op_src,
	input wire logic [11:0] op_dst,
	// Bank state and alternate map
	input wire logic [3:0] bank_ptr,
	input wire logic ext_set_en,
	input wire logic [11:0] ext_access_addr,
	// Formed addresses
	output logic [11:0] rd_addr,
	output logic [11:0] wr_addr
);
	logic [11:0] short_addr;

	// Short form: bank pointer or access-bank map
	always_comb begin
		if (op_access) begin
			short_addr = {bank_ptr, op_offset};
		end else if (ext_set_en) begin
			short_addr = ext_access_addr;
		end else if (op_offset < bdm_pkg::ACCESS_SPLIT) begin
			short_addr = {bdm_pkg::ACC_LOW_BANK, op_offset};
		end else begin
			short_addr = {bdm_pkg::ACC_HIGH_BANK, op_offset};
		end
	end

	// Full move ignores the bank pointer; all else uses the short form
	always_comb begin
		if (op_kind == bdm_pkg::OP_MOVE) begin
			rd_addr = op_src;
			wr_addr = op_dst;
		end else begin
			rd_addr = short_addr;
			wr_addr = short_addr;
		end
	end
endmodule

// ---- src/bdm_pkg.sv ----
// Constants and types for the banked data memory block.
// Assumes a 12-bit byte-addressed data space and a four-phase instruction cycle.
package bdm_pkg;
	// Address and data geometry
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	localparam int BANK_W = 4;
	localparam int OFS_W = 8;
	localparam int NUM_BANKS = 16;
	localparam int BANK_SIZE = 256;
	localparam int MEM_BYTES = 4096;
	// Access-bank split and bank choices
	localparam logic [7:0] ACCESS_SPLIT = 8'h60;
	localparam logic [3:0] ACC_LOW_BANK = 4'h0;
	localparam logic [3:0] ACC_HIGH_BANK = 4'hF;
	// Special function region and the bank pointer location
	localparam logic [11:0] SFR_BASE = 12'hF60;
	localparam logic [11:0] SFR_TOP = 12'hFFF;
	localparam logic [11:0] BANK_PTR_ADDR = 12'hFE0;
	// Bank pointer reset and its unused upper nibble
	localparam logic [3:0] BANK_PTR_RESET = 4'h0;
	localparam logic [3:0] BANK_PTR_UPPER = 4'h0;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	// Default maps of implemented and dual-access banks
	localparam logic [15:0] IMPL_BANKS_DEF = 16'h8007;
	localparam logic [15:0] USB_BANKS_DEF = 16'h0004;
	// Operations from the instruction decoder
	typedef enum logic [2:0] {
		OP_READ,
		OP_WRITE,
		OP_RMW,
		OP_MOVE,
		OP_LOAD_BANK
	} bdm_op_t;
	// Quarter phases of an instruction cycle
	typedef enum logic [1:0] {
		PH_Q1,
		PH_Q2,
		PH_Q3,
		PH_Q4
	} bdm_phase_t;
endpackage

// ---- src/bdm_ram.sv ----
// Byte-wide static data RAM, single port, registered read.
// Contents have no reset; the caller arbitrates the port.
`timescale 1ns/100ps
module bdm_ram #(
	parameter int AW = 12,
	parameter int DW = 8
) (
	// Clock
	input wire logic clk,
	// Port
	input wire logic we,
	input wire logic [AW-1:0] addr,
	input wire logic [DW-1:0] wdata,
	output logic [DW-1:0] rdata
);
	logic [DW-1:0] mem [0:(1 << AW)-1];

	// Storage is kept through every reset
	always_ff @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
	end
endmodule

// ---- src/bdm_top.sv ----
// Banked data memory: address forming, bank pointer, shared USB buffer RAM.
// Assumes the decoder holds one operation per four-clock instruction cycle.
//
// Behaviour
// - Twelve address bits, 4096 byte RAM locations
// - Sixteen banks of 256 bytes each
// - Unimplemented locations read as zero
// - USB banks plain storage unless USB enabled
// - Core and USB engine share buffer RAM
// - Banked address is pointer over operand
// - Bank pointer keeps four bits, upper zero
// - Load bank literal writes pointer directly
// - Unimplemented bank: writes dropped, reads zero
// - Full move uses 12-bit addresses only
// - Other ops resolve 8-bit offset via pointer or map
// - Access map: bank0 low, bank15 high
// - Access bit picks pointer or access map
// - Access-map operation completes in one cycle
// - Extended set selects alternate access mapping
// - General storage starts at address zero
// - General storage untouched by any reset
// - Special registers fill F60h to FFFh
// - Operand read Q2, destination write Q4
`timescale 1ns/100ps
module bdm_top #(
	parameter logic [15:0] IMPL_BANKS = bdm_pkg::IMPL_BANKS_DEF,
	parameter logic [15:0] USB_BANKS = bdm_pkg::USB_BANKS_DEF
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Instruction decoder side
	input wire logic op_valid,
	input wire bdm_pkg::bdm_op_t op_kind,
	input wire logic op_access,
	input wire logic [7:0] op_offset,
	input wire logic [11:0] op_src,
	input wire logic [11:0] op_dst,
	input wire logic [7:0] op_literal,
	input wire logic [7:0] wr_data,
	input wire logic ext_set_en,
	input wire logic [11:0] ext_access_addr,
	output bdm_pkg::bdm_phase_t phase,
	output logic [7:0] rd_data,
	output logic op_done,
	output logic [3:0] bank_ptr,
	// Peripheral special register port
	output logic sfr_re,
	output logic sfr_we,
	output logic [11:0] sfr_addr,
	output logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata,
	// USB serial engine side
	input wire logic usb_enable,
	input wire logic usb_req,
	input wire logic usb_we,
	input wire logic [11:0] usb_addr,
	input wire logic [7:0] usb_wdata,
	output logic usb_gnt,
	output logic usb_ack,
	output logic [7:0] usb_rdata
);
	bdm_pkg::bdm_phase_t phase_q;
	bdm_pkg::bdm_op_t kind_q;
	logic busy_q;
	logic access_q;
	logic [7:0] offset_q;
	logic [11:0] src_q;
	logic [11:0] dst_q;
	logic [7:0] literal_q;
	logic [3:0] bank_ptr_q;
	logic [7:0] rd_data_q;
	logic op_done_q;
	logic rd_ram_q;
	logic rd_bptr_q;
	logic rd_sfr_q;
	logic usb_rd_pend_q;
	logic usb_ack_q;
	logic [7:0] usb_rdata_q;
	logic [11:0] rd_addr;
	logic [11:0] wr_addr;
	logic does_read;
	logic does_write;
	logic rd_is_sfr;
	logic wr_is_sfr;
	logic rd_is_bptr;
	logic wr_is_bptr;
	logic rd_ram_ok;
	logic wr_ram_ok;
	logic usb_bank_ok;
	logic usb_slot;
	logic cpu_wr_now;
	logic ram_we;
	logic [11:0] ram_addr;
	logic [7:0] ram_wdata;
	logic [7:0] ram_rdata;
	logic [7:0] cpu_wdata;

	// Quarter-phase sequencer, one phase per clock
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			phase_q <= bdm_pkg::PH_Q1;
		end else begin
			case (phase_q)
				bdm_pkg::PH_Q1: phase_q <= bdm_pkg::PH_Q2;
				bdm_pkg::PH_Q2: phase_q <= bdm_pkg::PH_Q3;
				bdm_pkg::PH_Q3: phase_q <= bdm_pkg::PH_Q4;
				bdm_pkg::PH_Q4: phase_q <= bdm_pkg::PH_Q1;
				default: phase_q <= bdm_pkg::PH_Q1;
			endcase
		end
	end

	// Operation latch, taken at Q1
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busy_q <= 1'b0;
			kind_q <= bdm_pkg::OP_READ;
			access_q <= 1'b0;
			offset_q <= 8'h00;
			src_q <= 12'h000;
			dst_q <= 12'h000;
			literal_q <= 8'h00;
		end else if (phase_q == bdm_pkg::PH_Q1) begin
			busy_q <= op_valid;
			kind_q <= op_kind;
			access_q <= op_access;
			offset_q <= op_offset;
			src_q <= op_src;
			dst_q <= op_dst;
			literal_q <= op_literal;
		end
	end

	// Address forming for this cycle
	bdm_addr_gen u_addr (
		.op_kind(kind_q),
		.op_access(access_q),
		.op_offset(offset_q),
		.op_src(src_q),
		.op_dst(dst_q),
		.bank_ptr(bank_ptr_q),
		.ext_set_en(ext_set_en),
		.ext_access_addr(ext_access_addr),
		.rd_addr(rd_addr),
		.wr_addr(wr_addr)
	);

	// Operation class
	assign does_read = busy_q && (kind_q == bdm_pkg::OP_READ || kind_q == bdm_pkg::OP_RMW
		|| kind_q == bdm_pkg::OP_MOVE);
	assign does_write = busy_q && (kind_q == bdm_pkg::OP_WRITE || kind_q == bdm_pkg::OP_RMW
		|| kind_q == bdm_pkg::OP_MOVE);

	// Region decode: special registers on top, banks below
	assign rd_is_sfr = rd_addr >= bdm_pkg::SFR_BASE;
	assign wr_is_sfr = wr_addr >= bdm_pkg::SFR_BASE;
	assign rd_is_bptr = rd_addr == bdm_pkg::BANK_PTR_ADDR;
	assign wr_is_bptr = wr_addr == bdm_pkg::BANK_PTR_ADDR;
	assign rd_ram_ok = !rd_is_sfr && IMPL_BANKS[rd_addr[11:8]];
	assign wr_ram_ok = !wr_is_sfr && IMPL_BANKS[wr_addr[11:8]];

	// USB engine may use the RAM in Q1 and Q3 while enabled
	assign usb_bank_ok = USB_BANKS[usb_addr[11:8]] && IMPL_BANKS[usb_addr[11:8]];
	assign usb_slot = phase_q == bdm_pkg::PH_Q1 || phase_q == bdm_pkg::PH_Q3;
	assign usb_gnt = usb_req && usb_enable && usb_bank_ok && usb_slot;

	// RAM port: core read Q2, core write Q4, engine otherwise
	assign cpu_wr_now = phase_q == bdm_pkg::PH_Q4 && does_write;
	assign cpu_wdata = (kind_q == bdm_pkg::OP_MOVE) ? rd_data_q : wr_data;
	always_comb begin
		ram_we = 1'b0;
		ram_addr = rd_addr;
		ram_wdata = cpu_wdata;
		if (phase_q == bdm_pkg::PH_Q4) begin
			ram_addr = wr_addr;
			ram_we = cpu_wr_now && wr_ram_ok;
		end else if (usb_gnt) begin
			ram_addr = usb_addr;
			ram_wdata = usb_wdata;
			ram_we = usb_we;
		end
	end

	// One flat 4096-byte array, all banks
	bdm_ram #(
		.AW(bdm_pkg::ADDR_W),
		.DW(bdm_pkg::DATA_W)
	) u_ram (
		.clk(clk),
		.we(ram_we),
		.addr(ram_addr),
		.wdata(ram_wdata),
		.rdata(ram_rdata)
	);

	// Source of the operand, noted at Q2
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_ram_q <= 1'b0;
			rd_bptr_q <= 1'b0;
			rd_sfr_q <= 1'b0;
		end else if (phase_q == bdm_pkg::PH_Q2) begin
			rd_ram_q <= does_read && rd_ram_ok;
			rd_bptr_q <= does_read && rd_is_bptr;
			rd_sfr_q <= does_read && rd_is_sfr && !rd_is_bptr;
		end
	end

	// Operand capture at Q3; missing locations give zero
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_data_q <= bdm_pkg::ZERO_BYTE;
		end else if (phase_q == bdm_pkg::PH_Q3) begin
			if (rd_ram_q) begin
				rd_data_q <= ram_rdata;
			end else if (rd_bptr_q) begin
				rd_data_q <= {bdm_pkg::BANK_PTR_UPPER, bank_ptr_q};
			end else if (rd_sfr_q) begin
				rd_data_q <= sfr_rdata;
			end else begin
				rd_data_q <= bdm_pkg::ZERO_BYTE;
			end
		end
	end

	// Bank pointer: literal load or a data write to its location
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bank_ptr_q <= bdm_pkg::BANK_PTR_RESET;
		end else if (phase_q == bdm_pkg::PH_Q4 && busy_q) begin
			if (kind_q == bdm_pkg::OP_LOAD_BANK) begin
				bank_ptr_q <= literal_q[3:0];
			end else if (does_write && wr_is_bptr) begin
				bank_ptr_q <= cpu_wdata[3:0];
			end
		end
	end

	// Completion at Q4 for every operation, hit or miss
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			op_done_q <= 1'b0;
		end else begin
			op_done_q <= phase_q == bdm_pkg::PH_Q4 && busy_q;
		end
	end

	// Peripheral register strobes, core phases only
	assign sfr_re = phase_q == bdm_pkg::PH_Q2 && does_read && rd_is_sfr && !rd_is_bptr;
	assign sfr_we = cpu_wr_now && wr_is_sfr && !wr_is_bptr;
	assign sfr_addr = (phase_q == bdm_pkg::PH_Q4) ? wr_addr : rd_addr;
	assign sfr_wdata = cpu_wdata;

	// Engine ack one clock after grant, read data one clock after the ack
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			usb_rd_pend_q <= 1'b0;
			usb_ack_q <= 1'b0;
			usb_rdata_q <= bdm_pkg::ZERO_BYTE;
		end else begin
			usb_rd_pend_q <= usb_gnt && !usb_we;
			usb_ack_q <= usb_gnt;
			if (usb_rd_pend_q) begin
				usb_rdata_q <= ram_rdata;
			end
		end
	end

	// Outputs
	assign phase = phase_q;
	assign rd_data = rd_data_q;
	assign op_done = op_done_q;
	assign bank_ptr = bank_ptr_q;
	assign usb_ack = usb_ack_q;
	assign usb_rdata = usb_rdata_q;

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_quarters;
		phase_q == bdm_pkg::PH_Q2 ##1 phase_q == bdm_pkg::PH_Q3 ##1 phase_q == bdm_pkg::PH_Q4;
	endsequence

	sequence s_move_taken;
		phase_q == bdm_pkg::PH_Q1 && op_valid && op_kind == bdm_pkg::OP_MOVE;
	endsequence

	chk_phase_order: assert property (phase_q == bdm_pkg::PH_Q1 |=> s_quarters)
		else $error("quarter phases out of order");

	chk_done_timing: assert property (phase_q == bdm_pkg::PH_Q1 && op_valid |-> ##4 op_done_q)
		else $error("operation did not complete in its cycle");

	chk_move_copy: assert property (s_move_taken ##3 ram_we |-> ram_addr == dst_q && ram_wdata == rd_data_q)
		else $error("full move wrote wrong address or data");

	chk_literal_load: assert property (phase_q == bdm_pkg::PH_Q4 && busy_q && kind_q == bdm_pkg::OP_LOAD_BANK
		|=> bank_ptr_q == $past(literal_q[3:0]))
		else $error("bank pointer not loaded from literal");

	chk_upper_zero: assert property (phase_q == bdm_pkg::PH_Q4 && rd_bptr_q |-> rd_data_q[7:4] == bdm_pkg::BANK_PTR_UPPER
		&& rd_data_q[3:0] == bank_ptr_q)
		else $error("bank pointer read shows upper bits");

	chk_unimpl_read: assert property (phase_q == bdm_pkg::PH_Q2 && does_read && !rd_is_sfr
		&& !IMPL_BANKS[rd_addr[11:8]] |-> ##2 rd_data_q == bdm_pkg::ZERO_BYTE)
		else $error("unimplemented bank read not zero");

	chk_unimpl_write: assert property (ram_we |-> IMPL_BANKS[ram_addr[11:8]])
		else $error("write reached an unimplemented bank");

	chk_usb_refused: assert property (!usb_enable |-> !usb_gnt && !usb_ack_q ##1 !usb_ack_q)
		else $error("engine served while USB disabled");

	chk_access_map: assert property (busy_q && kind_q != bdm_pkg::OP_MOVE && !access_q && !ext_set_en
		|-> rd_addr[11:8] == (offset_q < bdm_pkg::ACCESS_SPLIT ? bdm_pkg::ACC_LOW_BANK : bdm_pkg::ACC_HIGH_BANK)
		&& rd_addr[7:0] == offset_q)
		else $error("access map address wrong");
endmodule

// ---- test/bdm_far_model.sv ----
// Far-side model: peripheral register port and USB serial engine.
// Assumes it is driven from the bench just after rising clock edges.
`timescale 1ns/100ps
module bdm_far_model (
	// Clock
	input wire logic clk,
	// Peripheral register port
	input wire logic sfr_re,
	input wire logic sfr_we,
	input wire logic [11:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	// USB serial engine port
	output logic usb_req,
	output logic usb_we,
	output logic [11:0] usb_addr,
	output logic [7:0] usb_wdata,
	input wire logic usb_gnt,
	input wire logic usb_ack,
	input wire logic [7:0] usb_rdata
);
	logic [11:0] last_addr;
	logic [7:0] last_data;
	logic [11:0] last_rd_addr;

	// Peripheral read data follows the address, so stale data never looks valid
	assign sfr_rdata = sfr_addr[7:0] ^ 8'h5A;

	// Record the last peripheral register write
	always @(posedge clk) begin
		if (sfr_we === 1'b1) begin
			last_addr <= sfr_addr;
			last_data <= sfr_wdata;
		end
		if (sfr_re === 1'b1) begin
			last_rd_addr <= sfr_addr;
		end
	end

	// Engine idle with request low
	initial begin
		usb_req = 1'b0;
		usb_we = 1'b0;
		usb_addr = 12'h000;
		usb_wdata = 8'h00;
	end

	// One engine access: hold until granted (bounded), take ack and read data
	task automatic usb_access(input logic we, input logic [11:0] a, input logic [7:0] wd,
		output logic [7:0] rd, output logic gnt_seen, output logic ack_seen);
		int n;
		n = 0;
		usb_req = 1'b1;
		usb_we = we;
		usb_addr = a;
		usb_wdata = wd;
		#1;
		while (usb_gnt !== 1'b1 && n < 8) begin
			@(posedge clk);
			#1;
			n++;
		end
		gnt_seen = (usb_gnt === 1'b1);
		@(posedge clk);
		#1;
		usb_req = 1'b0;
		usb_addr = ~a; // Released lines show no stale value
		usb_wdata = ~wd;
		ack_seen = usb_ack;
		@(posedge clk);
		#1;
		rd = usb_rdata;
	endtask
endmodule

// ---- test/tb_bdm_top.sv ----
// Self-checking bench for the banked data memory top.
// Assumes the far-side model answers the register port and USB engine.
`timescale 1ns/100ps
module tb_bdm_top;
	logic clk, rst, op_valid, op_access, ext_set_en, usb_enable;
	bdm_pkg::bdm_op_t op_kind;
	bdm_pkg::bdm_phase_t phase;
	logic [7:0] op_offset, op_literal, wr_data, rd_data, sfr_wdata, sfr_rdata, usb_wdata, usb_rdata, got;
	logic [11:0] op_src, op_dst, ext_access_addr, sfr_addr, usb_addr;
	logic op_done, sfr_re, sfr_we, usb_req, usb_we, usb_gnt, usb_ack, ok, ak;
	logic [3:0] bank_ptr;
	int num_errors, comparisons;

	bdm_top bdm_top_i (.clk(clk), .rst(rst), .op_valid(op_valid), .op_kind(op_kind), .op_access(op_access),
		.op_offset(op_offset), .op_src(op_src), .op_dst(op_dst), .op_literal(op_literal), .wr_data(wr_data),
		.ext_set_en(ext_set_en), .ext_access_addr(ext_access_addr), .phase(phase), .rd_data(rd_data),
		.op_done(op_done), .bank_ptr(bank_ptr), .sfr_re(sfr_re), .sfr_we(sfr_we), .sfr_addr(sfr_addr),
		.sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .usb_enable(usb_enable), .usb_req(usb_req),
		.usb_we(usb_we), .usb_addr(usb_addr), .usb_wdata(usb_wdata), .usb_gnt(usb_gnt), .usb_ack(usb_ack),
		.usb_rdata(usb_rdata));

	bdm_far_model bdm_far_model_i (.clk(clk), .sfr_re(sfr_re), .sfr_we(sfr_we), .sfr_addr(sfr_addr),
		.sfr_wdata(sfr_wdata),
		.sfr_rdata(sfr_rdata), .usb_req(usb_req), .usb_we(usb_we), .usb_addr(usb_addr), .usb_wdata(usb_wdata),
		.usb_gnt(usb_gnt), .usb_ack(usb_ack), .usb_rdata(usb_rdata));

	// 50 MHz clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Compare and count
	task automatic check(input logic [11:0] seen, input logic [11:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Verdict and end of run
	task automatic complete_run();
		$display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// One decoder operation: offered in Q1, read data taken in Q4, done checked next Q1
	task automatic do_op(input bdm_pkg::bdm_op_t k, input logic a, input logic [11:0] s,
		input logic [11:0] d, input logic [7:0] v);
		int n;
		n = 0;
		while (phase !== bdm_pkg::PH_Q1 && n < 8) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n == 8) begin
			num_errors++;
			complete_run();
		end
		op_kind = k;
		op_access = a;
		op_offset = s[7:0];
		op_src = s;
		op_dst = d;
		op_literal = v;
		wr_data = v;
		op_valid = 1'b1;
		@(posedge clk);
		#1;
		op_valid = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		got = rd_data;
		@(posedge clk);
		#1;
		check({11'h000, op_done}, 12'h001);
	endtask

	// Short forms of the operations
	task automatic wr(input logic a, input logic [7:0] o, input logic [7:0] v);
		do_op(bdm_pkg::OP_WRITE, a, {4'h0, o}, 12'h000, v);
	endtask
	task automatic rdc(input logic a, input logic [7:0] o, input logic [7:0] exp);
		do_op(bdm_pkg::OP_READ, a, {4'h0, o}, 12'h000, 8'h00);
		check({4'h0, got}, {4'h0, exp});
	endtask
	task automatic lb(input logic [7:0] v);
		do_op(bdm_pkg::OP_LOAD_BANK, 1'b0, 12'h000, 12'h000, v);
	endtask
	task automatic mv(input logic [11:0] s, input logic [11:0] d);
		do_op(bdm_pkg::OP_MOVE, 1'b0, s, d, 8'h00);
	endtask

	// Main sequence
	initial begin
		rst = 1'b1;
		op_valid = 1'b0;
		op_kind = bdm_pkg::OP_READ;
		op_access = 1'b0;
		op_offset = 8'h00;
		op_src = 12'h000;
		op_dst = 12'h000;
		op_literal = 8'h00;
		wr_data = 8'h00;
		ext_set_en = 1'b0;
		ext_access_addr = 12'h000;
		usb_enable = 1'b0;
		num_errors = 0;
		comparisons = 0;
		repeat (5) @(posedge clk);
		#1;
		rst = 1'b0;
		check({8'h00, bank_ptr}, 12'h000);
		lb(8'hF1);
		check({8'h00, bank_ptr}, 12'h001);
		rdc(1'b0, 8'hE0, 8'h01);
		wr(1'b0, 8'hE0, 8'hFF);
		rdc(1'b0, 8'hE0, 8'h0F);
		lb(8'h01);
		wr(1'b1, 8'h33, 8'hC3);
		wr(1'b0, 8'h33, 8'h3C);
		rdc(1'b1, 8'h33, 8'hC3);
		rdc(1'b0, 8'h33, 8'h3C);
		lb(8'h00);
		wr(1'b1, 8'h00, 8'h11);
		rdc(1'b0, 8'h00, 8'h11);
		lb(8'h0F);
		mv(12'h133, 12'hF10);
		rdc(1'b1, 8'h10, 8'hC3);
		rdc(1'b0, 8'h60, 8'h3A);
		check(bdm_far_model_i.last_rd_addr, 12'hF60);
		wr(1'b0, 8'h70, 8'h9D);
		check(bdm_far_model_i.last_addr, 12'hF70);
		check({4'h0, bdm_far_model_i.last_data}, 12'h09D);
		lb(8'h05);
		wr(1'b1, 8'h44, 8'h77);
		rdc(1'b1, 8'h44, 8'h00);
		mv(12'h544, 12'h020);
		rdc(1'b0, 8'h20, 8'h00);
		ext_set_en = 1'b1;
		ext_access_addr = 12'h133;
		rdc(1'b0, 8'h00, 8'hC3);
		ext_set_en = 1'b0;
		lb(8'h02);
		wr(1'b1, 8'h10, 8'hA5);
		bdm_far_model_i.usb_access(1'b0, 12'h210, 8'h00, got, ok, ak);
		check({11'h000, ok}, 12'h000);
		usb_enable = 1'b1;
		bdm_far_model_i.usb_access(1'b0, 12'h210, 8'h00, got, ok, ak);
		check({2'h0, ok, ak, got}, 12'h3A5);
		bdm_far_model_i.usb_access(1'b1, 12'h211, 8'h6B, got, ok, ak);
		rdc(1'b1, 8'h11, 8'h6B);
		bdm_far_model_i.usb_access(1'b0, 12'h110, 8'h00, got, ok, ak);
		check({11'h000, ok}, 12'h000);
		rst = 1'b1;
		@(posedge clk);
		#1;
		rst = 1'b0;
		lb(8'h01);
		rdc(1'b1, 8'h33, 8'hC3);
		do_op(bdm_pkg::OP_RMW, 1'b1, 12'h033, 12'h000, 8'h5E);
		check({4'h0, got}, 12'h0C3);
		rdc(1'b1, 8'h33, 8'h5E);
		complete_run();
	end
endmodule
